// File: bench/fb_model.sv
/* Outside wiring for divide-by-10/11.
 Assumes direct pin connections. */
`timescale 1ns/1ns
module fb_model (
	// Prescaler outputs
	input wire logic quinary_out,
	input wire logic binary_out,
	// Pins driven back
	output logic stage_clock,
	output logic fb_sel
);
	assign stage_clock = quinary_out;
	assign fb_sel = binary_out;
endmodule : fb_model

// File: bench/prescaler_props.sv
/* Port checker for the prescaler.
 Assumes bind onto the top module. */
`timescale 1ns/1ns
module prescaler_props (
	input wire logic clk, reset, mod_sel_ecl_a, mod_sel_ecl_b, mod_sel_ttl_a, mod_sel_ttl_b,
	input wire logic quinary_out, quinary_out_n, binary_stage_clock, binary_out, binary_out_n,
	input wire logic translate_in, translate_in_n, translate_out
);
	// Any select high asks for the short modulus
	wire logic sel = mod_sel_ecl_a | mod_sel_ecl_b | mod_sel_ttl_a | mod_sel_ttl_b;
	wire logic q = quinary_out;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Dwell, complement, toggle and translator relations
	property p_six; $rose(q) && !$past(sel) |-> q[*3] ##1 (!q)[*3] ##1 q; endproperty
	property p_five; $rose(q) && $past(sel) |-> q[*2] ##1 (!q)[*3] ##1 q; endproperty
	property p_qn; quinary_out_n != q; endproperty
	property p_bn; binary_out_n != binary_out; endproperty
	property p_tog; $rose(binary_stage_clock) |=> binary_out != $past(binary_out); endproperty
	property p_hold; !$rose(binary_stage_clock) |=> $stable(binary_out); endproperty
	property p_xl; translate_in != translate_in_n |=> translate_out == $past(translate_in); endproperty
	property p_xh; translate_in == translate_in_n |=> $stable(translate_out); endproperty
	a_six: assert property (p_six) else $error("six dwell wrong");
	a_five: assert property (p_five) else $error("five dwell wrong");
	a_qn: assert property (p_qn) else $error("quinary pair equal");
	a_bn: assert property (p_bn) else $error("binary pair equal");
	a_tog: assert property (p_tog) else $error("no toggle");
	a_hold: assert property (p_hold) else $error("stray toggle");
	a_xl: assert property (p_xl) else $error("translator missed");
	a_xh: assert property (p_xh) else $error("translator moved");
	c_five: cover property ($rose(q) && $past(sel));
	c_six: cover property ($rose(q) && !$past(sel));
	c_bin: cover property ($rose(binary_out));
endmodule : prescaler_props
bind two_modulus_prescaler prescaler_props u_props (.*);

// File: bench/tb_top.sv
/* Testbench: cascade with feedback model.
 Assumes checker bound to the design. */
`timescale 1ns/1ns
module tb_top;
	logic clk = 0, reset = 1, sel_b = 0, ttl_a = 0, ttl_b = 0, tin = 0, tin_n = 0;
	logic q, q_n, bclk, fb, b, b_n, tout;
	int error_cnt = 0, checks = 0;
	// Clock at 4 ns
	initial forever #2 clk = ~clk;
	two_modulus_prescaler u_dut (.clk(clk), .reset(reset), .mod_sel_ecl_a(fb), .mod_sel_ecl_b(sel_b),
		.mod_sel_ttl_a(ttl_a), .mod_sel_ttl_b(ttl_b), .quinary_out(q), .quinary_out_n(q_n),
		.binary_stage_clock(bclk), .binary_out(b), .binary_out_n(b_n), .translate_in(tin),
		.translate_in_n(tin_n), .translate_out(tout));
	fb_model u_fb (.quinary_out(q), .binary_out(b), .stage_clock(bclk), .fb_sel(fb));
	task automatic results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic check(input string name, input logic [5:0] exp, got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %0d seen %0d", name, exp, got);
		end
	endtask : check
	// Clocks between two rises of the binary output; first pass only syncs
	task automatic period(output logic [5:0] n);
		repeat (2) begin
			n = 6'h0;
			while (b !== 0 && n < 30) begin @(posedge clk); #1; n++; end
			while (b !== 1 && n < 30) begin @(posedge clk); #1; n++; end
		end
		if (n >= 30) begin error_cnt++; results(); end
	endtask : period
	// Each outside select alone forces ten
	task automatic t_moduli;
		logic [5:0] n;
		period(n);
		check("div11", 6'hB, n);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			{sel_b, ttl_a, ttl_b} <= 3'h4 >> i;
			period(n);
			check("div10", 6'hA, n);
		end
		@(posedge clk);
		{sel_b, ttl_a, ttl_b} <= 3'h0;
		period(n);
		check("div11 again", 6'hB, n);
	endtask : t_moduli
	// Counter control: upper modulus for the first two cycles, then the lower one;
	// the main count of three is kept no smaller than the upper-modulus count of two
	task automatic t_control;
		logic [5:0] n;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			sel_b <= (k >= 2);
			period(n);
			check("control", (k >= 2) ? 6'hA : 6'hB, n);
		end
		@(posedge clk);
		sel_b <= 1'h0;
	endtask : t_control
	// Differing pair is taken, equal pair holds
	task automatic t_xlate;
		@(posedge clk);
		{tin, tin_n} <= 2'h2;
		@(posedge clk);
		{tin, tin_n} <= 2'h3;
		@(posedge clk);
		#1;
		check("xlate high", 6'h1, {5'h0, tout});
		@(posedge clk);
		{tin, tin_n} <= 2'h1;
		@(posedge clk);
		#1;
		check("xlate low", 6'h0, {5'h0, tout});
	endtask : t_xlate
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		t_moduli();
		t_control();
		t_xlate();
		results();
	end
endmodule : tb_top

// File: rtl/binary_stage.sv
/*
 * Toggle (divide-by-two) stage with true and complement outputs.
 * Assumes its clock input is an ordinary signal sampled on clk; it toggles
 * on each rising transition seen on that input.
 */
`timescale 1ns/1ns
`include "prescaler_cfg.svh"

module binary_stage (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Stage clock and outputs
	input wire logic stage_clock,
	output logic binary_out,
	output logic binary_out_n
);

	logic stage_clock_ff;
	logic binary_ff;
	logic nxt_binary;

	// Edge history of the stage clock
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_clock_ff <= 1'h0;
		end else begin
			stage_clock_ff <= stage_clock;
		end
	end

	always_comb begin
		nxt_binary = binary_ff;
		if (stage_clock && !stage_clock_ff) begin
			nxt_binary = !binary_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			binary_ff <= `BINARY_RESET;
		end else begin
			binary_ff <= nxt_binary;
		end
	end

	// Both polarities registered from the same next value so they never disagree
	always_ff @(posedge clk) begin
		if (reset) begin
			binary_out <= `BINARY_RESET;
			binary_out_n <= !`BINARY_RESET;
		end else begin
			binary_out <= nxt_binary;
			binary_out_n <= !nxt_binary;
		end
	end

endmodule : binary_stage

// File: rtl/prescaler_cfg.svh
/*
 * Constants of the two-modulus prescaler: dwell counts of the quinary stage.
 * Assumes inclusion by bare name from design files.
 */
`ifndef PRESCALER_CFG_SVH
`define PRESCALER_CFG_SVH

// Input clocks the quinary output stays high in divide-by-six
`define HIGH_COUNT_DIV6 3'h3
// Input clocks the quinary output stays high in divide-by-five
`define HIGH_COUNT_DIV5 3'h2
// Input clocks the quinary output stays low in either modulus
`define LOW_COUNT 3'h3
// Reset levels of the stage outputs
`define QUINARY_RESET 1'h0
`define BINARY_RESET 1'h0

`endif

// File: rtl/prescaler_pkg.sv
/*
 * Types shared by the prescaler design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package prescaler_pkg;

	// Phase of the quinary stage waveform
	typedef enum logic [0:0] {
		PHASE_LOW,
		PHASE_HIGH
	} quinary_phase_t;

endpackage : prescaler_pkg

// File: rtl/two_modulus_prescaler.sv
/*
 * Two-modulus prescaler: divide-by-5/6 quinary stage, separately clocked
 * toggle stage, and level translator output. The input clock is clk itself;
 * every rising clk edge counts one input clock pulse.
 * Assumes the select inputs are synchronous to clk, and that outside logic
 * makes any feedback wiring and sequences the moduli.
 */
`timescale 1ns/1ns
`include "prescaler_cfg.svh"

// Function
// - Quinary stage divides input clock by five or six
// - All selects low: three high, three low
// - Any select high: two high, three low
// - Selects sampled only at rising-output edge
// - Four selects combined as logical OR
// - Binary output toggles on each stage-clock rise
// - Binary output fed back to a select
// - Feedback, others low: eleven clocks per period
// - Feedback, other select high: divide by ten
// - Translator reproduces translate_in while the pair differs
module two_modulus_prescaler (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Modulus selects
	input wire logic mod_sel_ecl_a,
	input wire logic mod_sel_ecl_b,
	input wire logic mod_sel_ttl_a,
	input wire logic mod_sel_ttl_b,
	// Quinary stage outputs
	output logic quinary_out,
	output logic quinary_out_n,
	// Binary stage clock and outputs
	input wire logic binary_stage_clock,
	output logic binary_out,
	output logic binary_out_n,
	// Level translator
	input wire logic translate_in,
	input wire logic translate_in_n,
	output logic translate_out
);

	prescaler_pkg::quinary_phase_t phase_ff;
	prescaler_pkg::quinary_phase_t nxt_phase;
	logic [2:0] dwell_ff;
	logic [2:0] nxt_dwell;
	logic short_ff;
	logic nxt_short;
	logic any_sel;

	assign any_sel = mod_sel_ecl_a | mod_sel_ecl_b | mod_sel_ttl_a | mod_sel_ttl_b;

	// Phase sequencer; dwell counts clk pulses spent in the current phase
	always_comb begin
		nxt_phase = phase_ff;
		nxt_dwell = dwell_ff + 3'h1;
		nxt_short = short_ff;
		case (phase_ff)
			prescaler_pkg::PHASE_LOW: begin
				if (dwell_ff == `LOW_COUNT) begin
					nxt_short = any_sel;
					nxt_phase = prescaler_pkg::PHASE_HIGH;
					nxt_dwell = 3'h1;
				end
			end
			prescaler_pkg::PHASE_HIGH: begin
				if ((short_ff && dwell_ff == `HIGH_COUNT_DIV5) ||
						(!short_ff && dwell_ff == `HIGH_COUNT_DIV6)) begin
					nxt_phase = prescaler_pkg::PHASE_LOW;
					nxt_dwell = 3'h1;
				end
			end
			default: begin
				nxt_phase = prescaler_pkg::PHASE_LOW;
				nxt_dwell = 3'h1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			phase_ff <= prescaler_pkg::PHASE_LOW;
			dwell_ff <= 3'h1;
			short_ff <= 1'h0;
		end else begin
			phase_ff <= nxt_phase;
			dwell_ff <= nxt_dwell;
			short_ff <= nxt_short;
		end
	end

	// registered outputs
	// Output flops follow the next phase so the pin matches the state exactly
	always_ff @(posedge clk) begin
		if (reset) begin
			quinary_out <= `QUINARY_RESET;
			quinary_out_n <= !`QUINARY_RESET;
		end else begin
			quinary_out <= (nxt_phase == prescaler_pkg::PHASE_HIGH);
			quinary_out_n <= (nxt_phase != prescaler_pkg::PHASE_HIGH);
		end
	end

	// feedback is external wiring of binary_out to a select
	binary_stage u_binary (
		.clk(clk),
		.reset(reset),
		.stage_clock(binary_stage_clock),
		.binary_out(binary_out),
		.binary_out_n(binary_out_n)
	);

	// translator follows
	// Differential pair: follow true input only when the pair disagrees,
	// so a momentary equal pair holds the last level instead of glitching
	always_ff @(posedge clk) begin
		if (reset) begin
			translate_out <= `BINARY_RESET;
		end else if (translate_in != translate_in_n) begin
			translate_out <= translate_in;
		end
	end

endmodule : two_modulus_prescaler
